//--- inc/ccf_defines.svh
`ifndef CCF_DEFINES_SVH
`define CCF_DEFINES_SVH

// ==========================================
// Register map
`define CCF_ADDR_CTRL4 12'h013
`define CCF_ADDR_CTRLX 12'h020
`define CCF_ADDR_STAT 12'h024
`define CCF_ADDR_VLIM 12'h028

// ==========================================
// Field positions in the control register
`define CCF_B_IN2_GATE 7
`define CCF_B_IN1_GATE 6
`define CCF_B_FREQ 5
`define CCF_B_STAT_OFF 4
`define CCF_B_SHORT_OFF 3
`define CCF_B_UVP_OFF 2
`define CCF_B_FORCE_DET 1
`define CCF_B_OCP_ON 0

// Fields in the auxiliary control register
`define CCF_B_MASTER_OFF 0
`define CCF_B_SW_RESET 1
`define CCF_B_WDOG_EXPIRE 2

// ==========================================
// Reset values
`define CCF_RST_CTRL4 8'h01
`define CCF_RST_STAT_OFF 1'b0
`define CCF_RST_OCP_ON 1'b1

// ==========================================
// Timing: settle time before the bus voltage sample
`define CCF_SETTLE_NS 1000
`define CCF_CLK_NS 8
`define CCF_SETTLE_CYC ((`CCF_SETTLE_NS + `CCF_CLK_NS - 1) / `CCF_CLK_NS)
// Edges after reset release before pins are captured
`define CCF_INIT_WAIT 2'h2

`endif

//--- inc/ccf_pkg.sv
package ccf_pkg;

    // Forced input-limit detection sequence
    typedef enum logic [3:0] {
        CCF_IDLE = 4'b0001,
        CCF_STOP = 4'b0010,
        CCF_MEAS = 4'b0100,
        CCF_LOAD = 4'b1000
    } ccf_det_type;

endpackage

//--- logic/ccf_charger_control_four.sv
`timescale 1ns/10ps
`default_nettype none
`include "ccf_defines.svh"

module ccf_charger_control_four #(
    parameter int VLIM_W = 8,
    parameter int SETTLE_CYC = `CCF_SETTLE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic config_strap_pin,
    input wire logic first_input_fet_pair,
    input wire logic second_input_fet_pair,
    input wire logic watchdog_expired,
    input wire logic vbat_above_min_sys,
    input wire logic vbus_meas_valid,
    input wire logic [VLIM_W-1:0] vbus_meas_value,
    output logic input2_gate_drive_on,
    output logic input1_gate_drive_on,
    output logic switching_frequency_select,
    output logic status_pin_off,
    output logic sys_short_hiccup_off,
    output logic reverse_undervolt_hiccup_off,
    output logic input_overcurrent_prot_on,
    output logic converter_stop,
    output logic vbus_meas_req,
    output logic [VLIM_W-1:0] input_voltage_limit
);

    // ==========================================
    // Pin synchronisers
    logic [1:0] strap_s_r;
    logic [1:0] fet1_s_r;
    logic [1:0] fet2_s_r;
    logic [1:0] wdog_s_r;
    logic [1:0] vbat_s_r;

    // Two flops per external level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_s_r <= 2'h0;
            fet1_s_r <= 2'h0;
            fet2_s_r <= 2'h0;
            wdog_s_r <= 2'h0;
            vbat_s_r <= 2'h0;
        end else if (clk_en) begin
            strap_s_r <= {strap_s_r[0], config_strap_pin};
            fet1_s_r <= {fet1_s_r[0], first_input_fet_pair};
            fet2_s_r <= {fet2_s_r[0], second_input_fet_pair};
            wdog_s_r <= {wdog_s_r[0], watchdog_expired};
            vbat_s_r <= {vbat_s_r[0], vbat_above_min_sys};
        end
    end

    // ==========================================
    // Power-on capture of presence and strap
    logic [1:0] init_cnt_r;
    logic init_done_r;
    logic init_take;
    logic fet1_here_r;
    logic fet2_here_r;
    logic strap_r;

    // Second sync flop holds the pin level only from the second edge on
    assign init_take = !init_done_r && (init_cnt_r == `CCF_INIT_WAIT);

    // Caught once the synchronisers have filled after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_cnt_r <= 2'h0;
            init_done_r <= 1'b0;
            fet1_here_r <= 1'b0;
            fet2_here_r <= 1'b0;
            strap_r <= 1'b0;
        end else if (clk_en && !init_done_r) begin
            init_cnt_r <= init_cnt_r + 2'h1;
            if (init_take) begin
                init_done_r <= 1'b1;
                fet1_here_r <= fet1_s_r[1];
                fet2_here_r <= fet2_s_r[1];
                strap_r <= strap_s_r[1];
            end
        end
    end

    // ==========================================
    // APB decode
    logic wr_en;
    logic rd_en;
    logic hit_ctrl4;
    logic hit_ctrlx;
    logic hit_stat;
    logic hit_vlim;
    logic mapped;

    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ref_a);
        addr_is = (a == ref_a);
    endfunction

    assign hit_ctrl4 = addr_is(paddr, `CCF_ADDR_CTRL4 << 2);
    assign hit_ctrlx = addr_is(paddr, `CCF_ADDR_CTRLX);
    assign hit_stat = addr_is(paddr, `CCF_ADDR_STAT);
    assign hit_vlim = addr_is(paddr, `CCF_ADDR_VLIM);
    assign mapped = hit_ctrl4 | hit_ctrlx | hit_stat | hit_vlim;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign wr_en = psel & penable & pwrite & mapped & clk_en & pstrb[0];
    assign rd_en = psel & penable & ~pwrite & clk_en;

    // ==========================================
    // Auxiliary control: master gate off, soft reset, watchdog expiry
    logic master_off_r;
    logic sw_reset;
    logic sw_wdog;
    logic wdog_prev_r;
    logic wdog_evt;

    assign sw_reset = wr_en & hit_ctrlx & pwdata[`CCF_B_SW_RESET];
    assign sw_wdog = wr_en & hit_ctrlx & pwdata[`CCF_B_WDOG_EXPIRE];

    // Master gate-drive disable bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            master_off_r <= 1'b0;
        end else if (clk_en) begin
            if (wr_en && hit_ctrlx) begin
                master_off_r <= pwdata[`CCF_B_MASTER_OFF];
            end
        end
    end

    // Rising edge of synchronised watchdog expiry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_prev_r <= 1'b0;
        end else if (clk_en) begin
            wdog_prev_r <= wdog_s_r[1];
        end
    end
    assign wdog_evt = (wdog_s_r[1] & ~wdog_prev_r) | sw_wdog;

    // ==========================================
    // Control register fields
    logic gate2_r;
    logic gate1_r;
    logic freq_r;
    logic stat_off_r;
    logic short_off_r;
    logic uvp_off_r;
    logic force_r;
    logic ocp_on_r;
    logic ctl_wr;
    logic det_done;

    assign ctl_wr = wr_en & hit_ctrl4;

    // Gate enables, locked off when pair absent or master off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate2_r <= 1'b0;
            gate1_r <= 1'b0;
        end else if (clk_en) begin
            if (master_off_r) begin
                gate2_r <= 1'b0;
                gate1_r <= 1'b0;
            end else if (ctl_wr) begin
                gate2_r <= pwdata[`CCF_B_IN2_GATE] & fet2_here_r & init_done_r;
                gate1_r <= pwdata[`CCF_B_IN1_GATE] & fet1_here_r & init_done_r;
            end
        end
    end

    // Frequency select, loaded from strap at power-on and soft reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_r <= 1'b0;
        end else if (clk_en) begin
            if (init_take) begin
                freq_r <= strap_s_r[1];
            end else if (sw_reset) begin
                freq_r <= strap_r;
            end else if (ctl_wr) begin
                freq_r <= pwdata[`CCF_B_FREQ];
            end
        end
    end

    // Status pin disable, cleared by watchdog or soft reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_off_r <= `CCF_RST_STAT_OFF;
        end else if (clk_en) begin
            if (wdog_evt || sw_reset) begin
                stat_off_r <= `CCF_RST_STAT_OFF;
            end else if (ctl_wr) begin
                stat_off_r <= pwdata[`CCF_B_STAT_OFF];
            end
        end
    end

    // Hiccup disables and overcurrent enable, soft reset only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            short_off_r <= 1'b0;
            uvp_off_r <= 1'b0;
            ocp_on_r <= `CCF_RST_OCP_ON;
        end else if (clk_en) begin
            if (sw_reset) begin
                short_off_r <= 1'b0;
                uvp_off_r <= 1'b0;
                ocp_on_r <= `CCF_RST_OCP_ON;
            end else if (ctl_wr) begin
                short_off_r <= pwdata[`CCF_B_SHORT_OFF];
                uvp_off_r <= pwdata[`CCF_B_UVP_OFF];
                ocp_on_r <= pwdata[`CCF_B_OCP_ON];
            end
        end
    end

    // Forced detection request; done and soft reset win over a write, reset returns it to 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            force_r <= 1'b0;
        end else if (clk_en) begin
            if (sw_reset || det_done) begin
                force_r <= 1'b0;
            end else if (ctl_wr && pwdata[`CCF_B_FORCE_DET] && vbat_s_r[1]) begin
                force_r <= 1'b1;
            end
        end
    end

    // ==========================================
    // Detection sequence
    ccf_pkg::ccf_det_type det_r;
    logic [15:0] settle_r;
    logic [VLIM_W-1:0] vlim_r;

    assign det_done = (det_r == ccf_pkg::CCF_LOAD);

    // Stop switching, settle, sample bus voltage, load limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            det_r <= ccf_pkg::CCF_IDLE;
            settle_r <= 16'h0000;
        end else if (clk_en) begin
            case (det_r)
                ccf_pkg::CCF_IDLE: begin
                    if (force_r && !sw_reset) begin
                        det_r <= ccf_pkg::CCF_STOP;
                        settle_r <= 16'(SETTLE_CYC);
                    end
                end
                ccf_pkg::CCF_STOP: begin
                    if (!force_r) begin
                        det_r <= ccf_pkg::CCF_IDLE;
                    end else if (settle_r <= 16'h0001) begin
                        det_r <= ccf_pkg::CCF_MEAS;
                    end else begin
                        settle_r <= settle_r - 16'h0001;
                    end
                end
                ccf_pkg::CCF_MEAS: begin
                    if (!force_r) begin
                        det_r <= ccf_pkg::CCF_IDLE;
                    end else if (vbus_meas_valid) begin
                        det_r <= ccf_pkg::CCF_LOAD;
                    end
                end
                ccf_pkg::CCF_LOAD: det_r <= ccf_pkg::CCF_IDLE;
                default: det_r <= ccf_pkg::CCF_IDLE;
            endcase
        end
    end

    // Input voltage limit loaded from the idle bus sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vlim_r <= '0;
        end else if (clk_en) begin
            if (det_r == ccf_pkg::CCF_MEAS && force_r && vbus_meas_valid) begin
                vlim_r <= vbus_meas_value;
            end else if (wr_en && hit_vlim) begin
                vlim_r <= pwdata[VLIM_W-1:0];
            end
        end
    end

    // ==========================================
    // Read data
    logic [7:0] ctl_view;
    assign ctl_view = {gate2_r, gate1_r, freq_r, stat_off_r,
                       short_off_r, uvp_off_r, force_r, ocp_on_r};

    // Registered read mux
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite && clk_en) begin
            if (hit_ctrl4) begin
                prdata <= {24'h00_0000, ctl_view};
            end else if (hit_ctrlx) begin
                prdata <= {31'h0000_0000, master_off_r};
            end else if (hit_stat) begin
                prdata <= {24'h00_0000, det_r, init_done_r, fet2_here_r, fet1_here_r,
                           strap_r};
            end else if (hit_vlim) begin
                prdata <= {{(32-VLIM_W){1'b0}}, vlim_r};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ==========================================
    // Outputs
    assign input2_gate_drive_on = gate2_r;
    assign input1_gate_drive_on = gate1_r;
    assign switching_frequency_select = freq_r;
    assign status_pin_off = stat_off_r;
    assign sys_short_hiccup_off = short_off_r;
    assign reverse_undervolt_hiccup_off = uvp_off_r;
    assign input_overcurrent_prot_on = ocp_on_r;
    assign converter_stop = (det_r != ccf_pkg::CCF_IDLE);
    assign vbus_meas_req = (det_r == ccf_pkg::CCF_MEAS);
    assign input_voltage_limit = vlim_r;

    logic unused_ok;
    assign unused_ok = rd_en & |pwdata[31:8] & |pstrb[3:1];

endmodule // ccf_charger_control_four

`default_nettype wire

//--- testbench/ccf_ctl4_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Control register checker
module ccf_ctl4_chk #(
    parameter int VLIM_W = 8,
    parameter int SETTLE_CYC = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic config_strap_pin,
    input wire logic first_input_fet_pair,
    input wire logic second_input_fet_pair,
    input wire logic watchdog_expired,
    input wire logic vbat_above_min_sys,
    input wire logic vbus_meas_valid,
    input wire logic [VLIM_W-1:0] vbus_meas_value,
    input wire logic input2_gate_drive_on,
    input wire logic input1_gate_drive_on,
    input wire logic switching_frequency_select,
    input wire logic status_pin_off,
    input wire logic sys_short_hiccup_off,
    input wire logic reverse_undervolt_hiccup_off,
    input wire logic input_overcurrent_prot_on,
    input wire logic converter_stop,
    input wire logic vbus_meas_req,
    input wire logic [VLIM_W-1:0] input_voltage_limit
);
    logic wr_ctl;
    logic wr_aux;
    logic [15:0] stop_cnt_r;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Decoded register writes
    assign wr_ctl = psel && penable && pwrite && clk_en && pstrb[0] && paddr == 12'h04c;
    assign wr_aux = psel && penable && pwrite && clk_en && pstrb[0] && paddr == 12'h020;
    // Cycles stopped before the measurement request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_cnt_r <= 16'h0000;
        end else if (!converter_stop) begin
            stop_cnt_r <= 16'h0000;
        end else if (!vbus_meas_req) begin
            stop_cnt_r <= stop_cnt_r + 16'h0001;
        end
    end
    gate2_lock_a: assert property (input2_gate_drive_on |-> second_input_fet_pair)
        else $error("second gate on without its pair");
    gate1_lock_a: assert property (input1_gate_drive_on |-> first_input_fet_pair)
        else $error("first gate on without its pair");
    stat_wdog_a: assert property ($rose(watchdog_expired) |-> ##[1:6] !status_pin_off)
        else $error("status disable kept after watchdog");
    hiccup_keep_a: assert property ($rose(watchdog_expired) |=>
        $stable({sys_short_hiccup_off, reverse_undervolt_hiccup_off})[*6])
        else $error("hiccup bits moved on watchdog");
    force_refuse_a: assert property (wr_ctl && pwdata[1] && !converter_stop
        && !vbat_above_min_sys && !$past(vbat_above_min_sys, 2) |-> ##2 !converter_stop)
        else $error("detection started with battery low");
    settle_time_a: assert property ($rose(vbus_meas_req) |->
        stop_cnt_r >= SETTLE_CYC - 1 && stop_cnt_r <= SETTLE_CYC + 1)
        else $error("measurement request at wrong time");
    meas_stop_a: assert property (vbus_meas_req |-> converter_stop)
        else $error("measuring while switching");
    limit_load_a: assert property (vbus_meas_req && vbus_meas_valid |=>
        input_voltage_limit == $past(vbus_meas_value))
        else $error("limit not loaded from measurement");
    det_done_a: assert property (vbus_meas_req && vbus_meas_valid |=>
        converter_stop ##1 !converter_stop)
        else $error("detection did not finish");
    gate_master_a: assert property (wr_aux && pwdata[0] |=> ##[0:2]
        !input1_gate_drive_on && !input2_gate_drive_on)
        else $error("gates on under master off");
    soft_rst_a: assert property (wr_aux && pwdata[1] |=> ##[0:3] input_overcurrent_prot_on
        && !status_pin_off && !sys_short_hiccup_off && !reverse_undervolt_hiccup_off)
        else $error("soft reset left fields set");
    cover property (wr_ctl && pwdata[1] && vbat_above_min_sys);
    cover property ($rose(vbus_meas_req));
    cover property (wr_aux && pwdata[1]);
endmodule // ccf_ctl4_chk

bind ccf_charger_control_four ccf_ctl4_chk #(.VLIM_W(VLIM_W), .SETTLE_CYC(SETTLE_CYC)) u_chk (.*);
`default_nettype wire

//--- testbench/test_charger_control_four.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Control register bench
module test_charger_control_four;
    localparam int VLIM_W = 8;
    localparam int SETTLE_CYC = 4;
    localparam logic [11:0] A_CTL = 12'h04c;
    localparam logic [11:0] A_AUX = 12'h020;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    logic config_strap_pin, first_input_fet_pair, second_input_fet_pair, watchdog_expired;
    logic vbat_above_min_sys, vbus_meas_valid, input2_gate_drive_on, input1_gate_drive_on;
    logic switching_frequency_select, status_pin_off, sys_short_hiccup_off, converter_stop;
    logic reverse_undervolt_hiccup_off, input_overcurrent_prot_on, vbus_meas_req;
    logic [VLIM_W-1:0] vbus_meas_value, input_voltage_limit, lim;
    logic [7:0] v, e;
    int mismatches, n_tests, seed, i, k;
    ccf_charger_control_four #(.VLIM_W(VLIM_W), .SETTLE_CYC(SETTLE_CYC)) dut (.*);
    // Clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Verdict
    task automatic test_done();
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Value comparison
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // One bus transfer, result in q and err
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        if (t >= 20) begin
            mismatches++;
            test_done();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Expected control byte: only first pair present
    function automatic logic [7:0] exp_ctl(input logic [7:0] x);
        return {1'b0, x[6:2], 1'b0, x[0]};
    endfunction
    // Main sequence
    initial begin
        seed = 32'haa68;
        mismatches = 0;
        n_tests = 0;
        presetn = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        config_strap_pin = 1'b1;
        first_input_fet_pair = 1'b1;
        second_input_fet_pair = 1'b0;
        watchdog_expired = 1'b0;
        vbat_above_min_sys = 1'b1;
        vbus_meas_valid = 1'b0;
        vbus_meas_value = 8'h00;
        cyc(10);
        presetn <= 1'b1;
        cyc(5);
        apb(1'b0, A_CTL, 32'h0);
        chk("ctl reset", 32'h21, q);
        chk("freq pin", 32'h1, {31'h0, switching_frequency_select});
        apb(1'b0, 12'h024, 32'h0);
        chk("status", 32'h1b, q);
        apb(1'b0, 12'h030, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        // Random writes, all ones except the force bit first
        for (i = 0; i < 24; i++) begin
            v = (i == 0) ? 8'hfd : 8'($random(seed));
            v[1] = 1'b0;
            e = exp_ctl(v);
            apb(1'b1, A_CTL, {24'h0, v});
            apb(1'b0, A_CTL, 32'h0);
            chk("ctl", {24'h0, e}, q);
            chk("pins", {24'h0, e}, {24'h0, input2_gate_drive_on, input1_gate_drive_on,
                switching_frequency_select, status_pin_off, sys_short_hiccup_off,
                reverse_undervolt_hiccup_off, 1'b0, input_overcurrent_prot_on});
        end
        // Watchdog clears only the status disable
        apb(1'b1, A_CTL, 32'h5d);
        watchdog_expired <= 1'b1;
        cyc(3);
        watchdog_expired <= 1'b0;
        cyc(6);
        apb(1'b0, A_CTL, 32'h0);
        chk("wdog", 32'h4d, q);
        // Master gate off clears and blocks gates
        apb(1'b1, A_AUX, 32'h1);
        apb(1'b1, A_CTL, 32'h4d);
        apb(1'b0, A_CTL, 32'h0);
        chk("master", 32'h0d, q);
        apb(1'b1, A_AUX, 32'h0);
        // Soft register reset
        apb(1'b1, A_CTL, 32'h5c);
        apb(1'b1, A_AUX, 32'h2);
        cyc(5);
        apb(1'b0, A_CTL, 32'h0);
        chk("soft rst", 32'h61, q);
        // Detection refused with battery low
        vbat_above_min_sys <= 1'b0;
        cyc(4);
        apb(1'b1, A_CTL, 32'h63);
        cyc(3);
        apb(1'b0, A_CTL, 32'h0);
        chk("refused", 32'h61, q);
        chk("no stop", 32'h0, {31'h0, converter_stop});
        // Forced detection
        vbat_above_min_sys <= 1'b1;
        cyc(4);
        lim = 8'($random(seed));
        apb(1'b1, A_CTL, 32'h63);
        k = 0;
        do begin
            @(negedge pclk);
            k++;
        end while (vbus_meas_req !== 1'b1 && k < 200);
        if (k >= 200) begin
            mismatches++;
            test_done();
        end
        chk("stopped", 32'h1, {31'h0, converter_stop});
        @(posedge pclk);
        vbus_meas_value <= lim;
        vbus_meas_valid <= 1'b1;
        @(posedge pclk);
        vbus_meas_valid <= 1'b0;
        cyc(4);
        apb(1'b0, 12'h028, 32'h0);
        chk("limit", {24'h0, lim}, q);
        chk("limit pin", {24'h0, lim}, {24'h0, input_voltage_limit});
        apb(1'b0, A_CTL, 32'h0);
        chk("force clr", 32'h61, q);
        chk("resume", 32'h0, {31'h0, converter_stop});
        chk("req off", 32'h0, {31'h0, vbus_meas_req});
        // Software watchdog event clears only the status disable
        apb(1'b1, A_CTL, 32'h71);
        apb(1'b1, A_AUX, 32'h4);
        apb(1'b0, A_CTL, 32'h0);
        chk("sw wdog", 32'h61, q);
        // Writes ignored with low strobe bit or clock enable low
        pstrb <= 4'he;
        apb(1'b1, A_CTL, 32'h70);
        pstrb <= 4'hf;
        clk_en <= 1'b0;
        apb(1'b1, A_CTL, 32'h70);
        clk_en <= 1'b1;
        apb(1'b0, A_CTL, 32'h0);
        chk("no write", 32'h61, q);
        // Limit register written from the bus
        lim = 8'($random(seed));
        apb(1'b1, 12'h028, {24'h0, lim});
        apb(1'b0, 12'h028, 32'h0);
        chk("limit wr", {24'h0, lim}, q);
        chk("limit wr pin", {24'h0, lim}, {24'h0, input_voltage_limit});
        test_done();
    end
endmodule // test_charger_control_four
`default_nettype wire
